// ===== common/hcfr_pkg.sv
// package: register map, field layout, reset values and types of the controller front registers
package hcfr_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] HCFR_OFF_VERSION = 8'h00;
	localparam logic [7:0] HCFR_OFF_ROM = 8'h04;
	localparam logic [7:0] HCFR_OFF_RETRY = 8'h08;
	localparam logic [7:0] HCFR_OFF_SWAP_NEW = 8'h0c;
	localparam logic [7:0] HCFR_OFF_SWAP_EXP = 8'h10;
	localparam logic [7:0] HCFR_OFF_SWAP_CTRL = 8'h14;
	localparam logic [7:0] HCFR_OFF_RES0 = 8'h18;
	localparam logic [7:0] HCFR_OFF_RES1 = 8'h1c;
	localparam logic [7:0] HCFR_OFF_RES2 = 8'h20;
	localparam logic [7:0] HCFR_OFF_RES3 = 8'h24;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int HCFR_VER_MAJOR_LSB = 16;
	localparam int HCFR_VER_PRESENT_BIT = 24;
	localparam int HCFR_ROM_CLEAR_BIT = 31;
	localparam int HCFR_ROM_GO_BIT = 25;
	localparam int HCFR_ROM_BYTE_LSB = 16;
	localparam int HCFR_RETRY_PHYS_LSB = 8;
	localparam int HCFR_RETRY_DRSP_LSB = 4;
	localparam int HCFR_RETRY_DREQ_LSB = 0;
	localparam int HCFR_SWAP_DONE_BIT = 31;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] HCFR_MAJOR_RST = 8'h01;
	localparam logic [7:0] HCFR_MINOR_RST = 8'h00;
	localparam logic [7:0] HCFR_MINOR_V11 = 8'h10;
	localparam logic [3:0] HCFR_RETRY_RST = 4'h0;
	localparam logic [31:0] HCFR_WORD_RST = 32'h0000_0000;
	localparam logic [31:0] HCFR_UNMAPPED_DATA = 32'h0000_0000;

	// ----------------------------------------
	// timing counts
	// ----------------------------------------
	localparam logic [3:0] HCFR_ADDR_CLEAR_CYCLES = 4'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		HCFR_SEL_BUS_MANAGER_ID = 2'h0,
		HCFR_SEL_BANDWIDTH_AVAILABLE = 2'h1,
		HCFR_SEL_CHANNELS_AVAILABLE_HI = 2'h2,
		HCFR_SEL_CHANNELS_AVAILABLE_LO = 2'h3
	} hcfr_sel_type;

	// byte-read request to the serial memory reader
	typedef struct packed {
		logic req;
		logic [7:0] addr;
	} hcfr_rom_req_type;

	// one retry limit set for the transmit units
	typedef struct packed {
		logic [3:0] phys_resp_retry_max;
		logic [3:0] dma_resp_retry_max;
		logic [3:0] dma_req_retry_max;
	} hcfr_retry_type;

	// values loaded from the serial memory at start-up
	typedef struct packed {
		logic valid;
		logic [7:0] major;
		logic [7:0] minor;
		logic [7:0] boot_image_offset;
	} hcfr_load_type;

endpackage : hcfr_pkg

// ===== hdl/hcfr_front_regs.sv
// design: controller front registers with serial memory read path, retry limits and compare-and-swap engine
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none

module hcfr_front_regs
	import hcfr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial memory start-up load
	input wire logic eeprom_present,
	input wire hcfr_load_type rom_load,
	// serial memory byte reader
	output hcfr_rom_req_type rom_req,
	input wire logic rom_ack,
	input wire logic [7:0] rom_data,
	// retry limits to the transmit units
	output hcfr_retry_type retry_limits,
	// bus-management resource contents
	output logic [31:0] bus_manager_id,
	output logic [31:0] bandwidth_available,
	output logic [31:0] channels_available_hi,
	output logic [31:0] channels_available_lo
);

	// elaboration check: the decode needs at least the full byte offset
	if (ADDR_W < 8) begin : g_addr_w_check
		$error("hcfr_front_regs: ADDR_W must be at least 8");
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic acc;
	logic wr;
	logic rd_ok;
	logic [7:0] off;
	logic mapped;

	assign off = paddr[7:0];
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd_ok = (paddr[ADDR_W-1:0] >> 8) == '0;
	assign mapped = rd_ok && (off[1:0] == 2'h0) && (off <= HCFR_OFF_SWAP_CTRL);

	// byte-enable merge for writable words
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	logic wr_rom;
	logic wr_retry;
	logic wr_new;
	logic wr_exp;
	logic wr_ctrl;

	assign wr_rom = wr && mapped && off == HCFR_OFF_ROM;
	assign wr_retry = wr && mapped && off == HCFR_OFF_RETRY;
	assign wr_new = wr && mapped && off == HCFR_OFF_SWAP_NEW;
	assign wr_exp = wr && mapped && off == HCFR_OFF_SWAP_EXP;
	assign wr_ctrl = wr && mapped && off == HCFR_OFF_SWAP_CTRL;

	// ----------------------------------------
	// version register
	// ----------------------------------------
	logic [7:0] major_r;
	logic [7:0] minor_r;
	logic present_r;
	logic [7:0] boot_off_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			major_r <= HCFR_MAJOR_RST;
			minor_r <= HCFR_MINOR_RST;
			boot_off_r <= 8'h00;
		end else if (rom_load.valid && eeprom_present) begin
			major_r <= rom_load.major;
			minor_r <= rom_load.minor;
			boot_off_r <= rom_load.boot_image_offset;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			present_r <= 1'b0;
		end else begin
			present_r <= eeprom_present;
		end
	end

	// ----------------------------------------
	// serial memory read path
	// ----------------------------------------
	logic clear_r;
	logic [3:0] clear_cnt_r;
	logic go_r;
	logic [7:0] byte_r;
	logic [7:0] rom_addr_r;
	logic req_r;

	// address clear takes a short fixed hold before the bit drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_r <= 1'b0;
			clear_cnt_r <= 4'h0;
		end else if (wr_rom && pstrb[3] && pwdata[HCFR_ROM_CLEAR_BIT]) begin
			clear_r <= 1'b1;
			clear_cnt_r <= HCFR_ADDR_CLEAR_CYCLES;
		end else if (clear_r) begin
			if (clear_cnt_r == 4'h1) begin
				clear_r <= 1'b0;
			end
			clear_cnt_r <= clear_cnt_r - 4'h1;
		end
	end

	// read-go stays set until the reader acknowledges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_r <= 1'b0;
			req_r <= 1'b0;
		end else begin
			if (go_r && req_r && rom_ack) begin
				go_r <= 1'b0;
				req_r <= 1'b0;
			end else if (wr_rom && pstrb[3] && pwdata[HCFR_ROM_GO_BIT] && !go_r) begin
				go_r <= 1'b1;
			end else if (go_r && !clear_r) begin
				req_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_r <= 8'h00;
		end else if (go_r && req_r && rom_ack) begin
			byte_r <= rom_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_addr_r <= 8'h00;
		end else if (clear_r) begin
			rom_addr_r <= 8'h00;
		end else if (go_r && req_r && rom_ack) begin
			rom_addr_r <= rom_addr_r + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_req <= '0;
		end else begin
			rom_req.req <= go_r && !clear_r && !(req_r && rom_ack);
			rom_req.addr <= rom_addr_r;
		end
	end

	// ----------------------------------------
	// retry limits
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_limits.phys_resp_retry_max <= HCFR_RETRY_RST;
			retry_limits.dma_resp_retry_max <= HCFR_RETRY_RST;
			retry_limits.dma_req_retry_max <= HCFR_RETRY_RST;
		end else if (wr_retry) begin
			if (pstrb[1]) begin
				retry_limits.phys_resp_retry_max <= pwdata[HCFR_RETRY_PHYS_LSB +: 4];
			end
			if (pstrb[0]) begin
				retry_limits.dma_resp_retry_max <= pwdata[HCFR_RETRY_DRSP_LSB +: 4];
				retry_limits.dma_req_retry_max <= pwdata[HCFR_RETRY_DREQ_LSB +: 4];
			end
		end
	end

	// ----------------------------------------
	// compare-and-swap engine
	// ----------------------------------------
	typedef enum logic [1:0] {
		HCFR_SW_IDLE,
		HCFR_SW_RUN
	} hcfr_sw_state_type;

	hcfr_sw_state_type sw_state_r;
	logic [31:0] swap_new_value;
	logic [31:0] swap_expected_value;
	hcfr_sel_type swap_target_select;
	logic swap_complete;
	logic [31:0] res_r [4];
	logic [31:0] cur;

	assign cur = res_r[swap_target_select];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state_r <= HCFR_SW_IDLE;
		end else begin
			unique case (sw_state_r)
				HCFR_SW_IDLE: begin
					if (wr_ctrl) begin
						sw_state_r <= HCFR_SW_RUN;
					end
				end
				HCFR_SW_RUN: begin
					sw_state_r <= HCFR_SW_IDLE;
				end
				default: begin
					sw_state_r <= HCFR_SW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swap_target_select <= HCFR_SEL_BUS_MANAGER_ID;
		end else if (wr_ctrl && pstrb[0] && sw_state_r == HCFR_SW_IDLE) begin
			swap_target_select <= hcfr_sel_type'(pwdata[1:0]);
		end
	end

	// completion set wins over a write that lands in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swap_complete <= 1'b1;
		end else if (sw_state_r == HCFR_SW_RUN) begin
			swap_complete <= 1'b1;
		end else if (wr_ctrl) begin
			swap_complete <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swap_new_value <= HCFR_WORD_RST;
		end else if (sw_state_r == HCFR_SW_RUN) begin
			swap_new_value <= cur;
		end else if (wr_new) begin
			swap_new_value <= merge(swap_new_value, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swap_expected_value <= HCFR_WORD_RST;
		end else if (wr_exp) begin
			swap_expected_value <= merge(swap_expected_value, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				res_r[i] <= HCFR_WORD_RST;
			end
		end else if (sw_state_r == HCFR_SW_RUN && cur == swap_expected_value) begin
			res_r[swap_target_select] <= swap_new_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_manager_id <= HCFR_WORD_RST;
			bandwidth_available <= HCFR_WORD_RST;
			channels_available_hi <= HCFR_WORD_RST;
			channels_available_lo <= HCFR_WORD_RST;
		end else begin
			bus_manager_id <= res_r[HCFR_SEL_BUS_MANAGER_ID];
			bandwidth_available <= res_r[HCFR_SEL_BANDWIDTH_AVAILABLE];
			channels_available_hi <= res_r[HCFR_SEL_CHANNELS_AVAILABLE_HI];
			channels_available_lo <= res_r[HCFR_SEL_CHANNELS_AVAILABLE_LO];
		end
	end

	// ----------------------------------------
	// read mux and apb answer
	// ----------------------------------------
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = HCFR_UNMAPPED_DATA;
		unique case (off)
			HCFR_OFF_VERSION: begin
				rd_nxt[HCFR_VER_MAJOR_LSB +: 8] = major_r;
				rd_nxt[7:0] = minor_r;
				rd_nxt[HCFR_VER_PRESENT_BIT] = present_r;
			end
			HCFR_OFF_ROM: begin
				rd_nxt[HCFR_ROM_CLEAR_BIT] = clear_r;
				rd_nxt[HCFR_ROM_GO_BIT] = go_r;
				rd_nxt[HCFR_ROM_BYTE_LSB +: 8] = byte_r;
				rd_nxt[7:0] = boot_off_r;
			end
			HCFR_OFF_RETRY: begin
				rd_nxt[HCFR_RETRY_PHYS_LSB +: 4] = retry_limits.phys_resp_retry_max;
				rd_nxt[HCFR_RETRY_DRSP_LSB +: 4] = retry_limits.dma_resp_retry_max;
				rd_nxt[HCFR_RETRY_DREQ_LSB +: 4] = retry_limits.dma_req_retry_max;
			end
			HCFR_OFF_SWAP_NEW: begin
				rd_nxt = swap_new_value;
			end
			HCFR_OFF_SWAP_EXP: begin
				rd_nxt = swap_expected_value;
			end
			HCFR_OFF_SWAP_CTRL: begin
				rd_nxt[HCFR_SWAP_DONE_BIT] = swap_complete;
				rd_nxt[1:0] = swap_target_select;
			end
			default: begin
				rd_nxt = HCFR_UNMAPPED_DATA;
			end
		endcase
		if (!mapped) begin
			rd_nxt = HCFR_UNMAPPED_DATA;
		end
	end

	// zero-wait answer: pready rises in every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= HCFR_WORD_RST;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_nxt;
			end
		end
	end

endmodule : hcfr_front_regs

`default_nettype wire

// ===== testbench/hcfr_front_regs_checker.sv
// checker: apb answer timing, reserved fields, serial memory request and swap side effects
`timescale 1ns/10ps
`default_nettype none
module hcfr_front_regs_checker
	import hcfr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// serial memory
	input wire logic eeprom_present,
	input wire hcfr_rom_req_type rom_req,
	input wire logic rom_ack,
	// resources
	input wire logic [31:0] bus_manager_id,
	input wire logic [31:0] bandwidth_available,
	input wire logic [31:0] channels_available_hi,
	input wire logic [31:0] channels_available_lo
);
	logic ctl_wr;
	logic ver_rd;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign ctl_wr = psel && penable && pwrite && pready && paddr == HCFR_OFF_SWAP_CTRL;
	assign ver_rd = psel && penable && !pwrite && pready && paddr == HCFR_OFF_VERSION;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd(logic [7:0] a);
		psel && penable && !pwrite && pready && !pslverr && paddr == a;
	endsequence
	AST_APB_ANSWER: assert property (s_setup |=> pready) else $error("no answer one cycle after setup");
	AST_READY_QUAL: assert property (pready |-> psel && penable) else $error("ready outside access phase");
	AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("error without ready");
	AST_VER_RSVD: assert property (s_rd(HCFR_OFF_VERSION) |-> prdata[31:25] == 7'h0 && prdata[15:8] == 8'h0)
		else $error("version reserved bits set");
	AST_VER_PRESENT: assert property (ver_rd && $past(eeprom_present, 4) == eeprom_present
		&& $past(eeprom_present, 2) == eeprom_present && $past(eeprom_present, 3) == eeprom_present
		|-> prdata[24] == eeprom_present) else $error("memory present flag wrong");
	AST_ROM_RSVD: assert property (s_rd(HCFR_OFF_ROM) |-> prdata[30:26] == 5'h0 && !prdata[24]
		&& prdata[15:8] == 8'h0) else $error("memory read reserved bits set");
	AST_RETRY_RSVD: assert property (s_rd(HCFR_OFF_RETRY) |-> prdata[31:12] == 20'h0)
		else $error("retry upper bits set");
	AST_SWAP_RSVD: assert property (s_rd(HCFR_OFF_SWAP_CTRL) |-> prdata[30:2] == 29'h0)
		else $error("swap control reserved bits set");
	AST_REQ_HOLD: assert property (rom_req.req && !rom_ack |=> rom_req.req && $stable(rom_req.addr))
		else $error("byte request dropped before answer");
	AST_REQ_DROP: assert property (rom_req.req && rom_ack |=> !rom_req.req)
		else $error("byte request kept after answer");
	AST_RES_CAUSE: assert property ($changed({bus_manager_id, bandwidth_available, channels_available_hi,
		channels_available_lo}) |-> $past(ctl_wr, 2) || $past(ctl_wr, 3) || $past(ctl_wr, 4))
		else $error("resource changed without swap");
endmodule : hcfr_front_regs_checker
bind hcfr_front_regs hcfr_front_regs_checker #(.ADDR_W(ADDR_W)) hcfr_front_regs_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_present(eeprom_present),
	.rom_req(rom_req), .rom_ack(rom_ack), .bus_manager_id(bus_manager_id),
	.bandwidth_available(bandwidth_available), .channels_available_hi(channels_available_hi),
	.channels_available_lo(channels_available_lo));
`default_nettype wire

// ===== testbench/hcfr_rom_model.sv
// partner: serial memory byte reader answering promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module hcfr_rom_model
	import hcfr_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// reader handshake
	input wire hcfr_rom_req_type rom_req,
	input wire logic slow,
	output logic rom_ack,
	output logic [7:0] rom_data
);
	logic [3:0] wait_r;
	// byte is a pattern of the address; data toggles while not answering
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_ack <= 1'b0;
			rom_data <= 8'h00;
			wait_r <= 4'h0;
		end else if (rom_ack) begin
			rom_ack <= 1'b0;
			rom_data <= ~rom_data;
			wait_r <= 4'h0;
		end else if (rom_req.req && wait_r >= (slow ? 4'h6 : 4'h0)) begin
			rom_ack <= 1'b1;
			rom_data <= rom_req.addr ^ 8'h5a;
		end else begin
			wait_r <= rom_req.req ? wait_r + 4'h1 : 4'h0;
			rom_data <= ~rom_data;
		end
	end
endmodule : hcfr_rom_model
`default_nettype wire

// ===== testbench/hcfr_front_regs_tb.sv
// testbench: front registers driven over apb against a serial memory model
`timescale 1ns/10ps
`default_nettype none
`define CHK(NM, EX, GT) begin n_compared++; if ((GT) !== (EX)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", NM, EX, GT); end end
module hcfr_front_regs_tb
	import hcfr_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic eeprom_present = 1'b0, slow = 1'b0, pready, pslverr, e, rom_ack;
	logic [7:0] paddr = 8'h00, rom_data, ma = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, v, lf = 32'h1dc7;
	logic [31:0] res [4];
	logic [31:0] mres [4] = '{default: 32'h0};
	hcfr_load_type rom_load = '0;
	hcfr_rom_req_type rom_req;
	hcfr_retry_type retry_limits;
	int error_cnt = 0, n_compared = 0;
	always #20 pclk = ~pclk;
	hcfr_front_regs #(.ADDR_W(8)) hcfr_front_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .eeprom_present(eeprom_present), .rom_load(rom_load),
		.rom_req(rom_req), .rom_ack(rom_ack), .rom_data(rom_data), .retry_limits(retry_limits),
		.bus_manager_id(res[0]), .bandwidth_available(res[1]), .channels_available_hi(res[2]),
		.channels_available_lo(res[3]));
	hcfr_rom_model hcfr_rom_model_i (.pclk(pclk), .presetn(presetn), .rom_req(rom_req), .slow(slow),
		.rom_ack(rom_ack), .rom_data(rom_data));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// serial memory register after a finished read: model byte pattern and boot image offset
	function automatic logic [31:0] rom_word(input logic [7:0] a, input logic [7:0] boot);
		return {8'h00, a ^ 8'h5a, 8'h00, boot};
	endfunction : rom_word
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll(input logic [7:0] a, input int b, input logic want);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while (q[b] !== want && n < 50);
	endtask : poll
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0); `CHK("version", 32'h0001_0000, q)
		apb(1'b0, 8'h14, 32'h0); `CHK("swapctl", 32'h8000_0000, q)
		apb(1'b0, 8'h18, 32'h0); `CHK("unmapped", 33'h1_0000_0000, {e, q})
		apb(1'b1, 8'h00, 32'hffff_ffff);
		apb(1'b0, 8'h00, 32'h0); `CHK("ver_ro", 33'h0_0001_0000, {e, q})
		eeprom_present <= 1'b1;
		rom_load <= '{1'b1, 8'h01, 8'h10, 8'h40}; // link feature options lie outside this block
		@(posedge pclk);
		rom_load.valid <= 1'b0;
		apb(1'b0, 8'h00, 32'h0); `CHK("ver_load", 32'h0101_0010, q)
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			v = (i == 0) ? 32'hffff_ffff : lf;
			apb(1'b1, 8'h08, v);
			apb(1'b0, 8'h08, 32'h0); `CHK("retry", v & 32'h0000_0fff, q)
			`CHK("retry_out", v[11:0], retry_limits)
		end
		// memory reads alternate prompt and slow answers, with an address clear before the first and the last
		for (int i = 0; i < 6; i++) begin
			if (i == 0 || i == 5) begin
				apb(1'b1, 8'h04, 32'h8000_0000);
				apb(1'b0, 8'h04, 32'h0); `CHK("clr_busy", 1'b1, q[31])
				poll(8'h04, 31, 1'b0);
				ma = 8'h00;
			end
			slow <= i[0];
			apb(1'b1, 8'h04, 32'h0200_0000);
			poll(8'h04, 25, 1'b0); `CHK("romrd", rom_word(ma, 8'h40), q)
			ma = ma + 8'h01;
		end
		for (int s = 0; s < 4; s++) begin
			for (int j = 0; j < 2; j++) begin
				lf = lfsr(lf);
				apb(1'b1, 8'h0c, lf);
				apb(1'b1, 8'h10, mres[s] ^ {31'h0, j[0]});
				apb(1'b1, 8'h14, {30'h0, s[1:0]});
				poll(8'h14, 31, 1'b1); `CHK("swapctl", {1'b1, 29'h0, s[1:0]}, q)
				apb(1'b0, 8'h0c, 32'h0); `CHK("old", mres[s], q)
				if (j == 0)
					mres[s] = lf;
				`CHK("res", mres[s], res[s])
			end
		end
		summarize();
	end
endmodule : hcfr_front_regs_tb
`default_nettype wire
